// ---- design/vsst_pkg.sv ----
package vsst_pkg;

  // --------------------------------------------------------------------------
  // host register addresses and fields
  // --------------------------------------------------------------------------
  localparam logic [7:0] VSST_ADDR_MASK0      = 8'h11;
  localparam logic [7:0] VSST_ADDR_MASK1      = 8'h12;
  localparam logic [7:0] VSST_ADDR_MASK2      = 8'h13;
  localparam logic [7:0] VSST_ADDR_OUT_CONFIG = 8'h80;
  localparam logic [7:0] VSST_ADDR_HOST_CODE  = 8'h81;
  localparam logic [7:0] VSST_ADDR_HD_CONTROL = 8'h82;
  localparam logic [7:0] VSST_ADDR_STATUS     = 8'h83;
  localparam int         VSST_HOST_SEL_BIT    = 1;
  localparam int         VSST_HD_ON_BIT       = 7;
  localparam int         VSST_RECOG_BIT       = 7;
  localparam logic [23:0] VSST_MASK_RESET     = 24'hff_ffff;
  localparam logic [7:0] VSST_OUT_CONFIG_RESET = 8'h00;
  localparam logic [5:0] VSST_HOST_CODE_RESET = 6'h00;
  localparam logic [7:0] VSST_HD_CONTROL_RESET = 8'h00;
  localparam logic [5:0] VSST_FIRST_HD_CODE   = 6'h0b;
  localparam int         VSST_NUM_CODES       = 13;

  // --------------------------------------------------------------------------
  // pixel clock rates
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    VSST_RATE_NONE   = 3'h0,
    VSST_RATE_14M32  = 3'h1,
    VSST_RATE_27M    = 3'h2,
    VSST_RATE_36M    = 3'h3,
    VSST_RATE_54M    = 3'h4,
    VSST_RATE_74M25  = 3'h5,
    VSST_RATE_74M175 = 3'h6,
    VSST_RATE_COMPOSITE = 3'h7
  } vsst_rate_type;

  typedef struct packed {
    vsst_rate_type rate;
    logic [11:0]   total;
    logic [9:0]    lines;
    logic [11:0]   active;
    logic [7:0]    hs_width;
    logic [3:0]    vs_half;
    logic [9:0]    active_lines;
    logic          tri_level;
  } vsst_fmt_type;

  // --------------------------------------------------------------------------
  // format table, vertical sync in half lines
  // --------------------------------------------------------------------------
  localparam vsst_fmt_type VSST_FMT_NONE = '0;
  localparam vsst_fmt_type VSST_FMT_01 = '{VSST_RATE_14M32, 12'h38e, 10'h20d,
    12'h300, 8'h1d, 4'h6, 10'h1e6, 1'b0};
  localparam vsst_fmt_type VSST_FMT_02 = '{VSST_RATE_COMPOSITE, 12'h000,
    10'h271, 12'h000, 8'h00, 4'h5, 10'h240, 1'b0};
  localparam vsst_fmt_type VSST_FMT_03 = '{VSST_RATE_27M, 12'h6b4, 10'h20d,
    12'h5a0, 8'h7f, 4'h6, 10'h1e6, 1'b0};
  localparam vsst_fmt_type VSST_FMT_04 = '{VSST_RATE_27M, 12'h6c0, 10'h271,
    12'h5a0, 8'h7f, 4'h5, 10'h240, 1'b0};
  localparam vsst_fmt_type VSST_FMT_05 = '{VSST_RATE_36M, 12'h8f0, 10'h20d,
    12'h780, 8'ha9, 4'h6, 10'h1e6, 1'b0};
  localparam vsst_fmt_type VSST_FMT_06 = '{VSST_RATE_36M, 12'h900, 10'h271,
    12'h780, 8'ha9, 4'h5, 10'h240, 1'b0};
  localparam vsst_fmt_type VSST_FMT_07 = '{VSST_RATE_54M, 12'hd68, 10'h20d,
    12'hb40, 8'hfc, 4'h6, 10'h1e6, 1'b0};
  localparam vsst_fmt_type VSST_FMT_08 = '{VSST_RATE_54M, 12'hd80, 10'h271,
    12'hb40, 8'hfc, 4'h5, 10'h240, 1'b0};
  localparam vsst_fmt_type VSST_FMT_09 = '{VSST_RATE_54M, 12'h6b4, 10'h20d,
    12'h5a0, 8'h7f, 4'hc, 10'h1e3, 1'b0};
  localparam vsst_fmt_type VSST_FMT_10 = '{VSST_RATE_54M, 12'h6c0, 10'h271,
    12'h5a0, 8'h7f, 4'ha, 10'h240, 1'b0};
  localparam vsst_fmt_type VSST_FMT_11 = '{VSST_RATE_74M25, 12'h672, 10'h2ee,
    12'h500, 8'h50, 4'ha, 10'h2d0, 1'b1};
  localparam vsst_fmt_type VSST_FMT_12 = '{VSST_RATE_74M175, 12'h672,
    10'h2ee, 12'h500, 8'h50, 4'ha, 10'h2d0, 1'b1};

  function automatic vsst_fmt_type vsst_format(input logic [5:0] code);
    unique case (code)
      6'h01:   return VSST_FMT_01;
      6'h02:   return VSST_FMT_02;
      6'h03:   return VSST_FMT_03;
      6'h04:   return VSST_FMT_04;
      6'h05:   return VSST_FMT_05;
      6'h06:   return VSST_FMT_06;
      6'h07:   return VSST_FMT_07;
      6'h08:   return VSST_FMT_08;
      6'h09:   return VSST_FMT_09;
      6'h0a:   return VSST_FMT_10;
      6'h0b:   return VSST_FMT_11;
      6'h0c:   return VSST_FMT_12;
      default: return VSST_FMT_NONE;
    endcase
  endfunction

endpackage

// ---- design/vsst_timing_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module vsst_timing_gen (
  input  wire  logic                   clock,
  input  wire  logic                   rstn,
  input  wire  logic [5:0]             format_select_code,
  input  wire  logic [7:0]             reg_addr,
  input  wire  logic [7:0]             reg_wdata,
  input  wire  logic                   reg_write,
  output var   logic [7:0]             reg_rdata,
  input  wire  logic                   ref_measure_valid,
  input  wire  logic [11:0]            ref_line_clocks,
  input  wire  logic [9:0]             ref_frame_lines,
  input  wire  vsst_pkg::vsst_rate_type ref_rate,
  output var   logic [5:0]             detected_code,
  output var   logic                   ref_recognized,
  output var   logic                   ref_tri_level,
  output var   logic [5:0]             active_code,
  output var   vsst_pkg::vsst_rate_type pixel_rate,
  output var   logic                   line_sync_n,
  output var   logic                   frame_sync_n,
  output var   logic                   display_enable,
  output var   logic                   single_ended_pixel_clock_a,
  output var   logic                   single_ended_pixel_clock_b,
  output var   logic                   differential_pixel_clock_p,
  output var   logic                   differential_pixel_clock_n,
  output var   logic                   differential_pixel_clock_oe
);
  import vsst_pkg::*;

  // --------------------------------------------------------------------------
  // reset release and pin synchroniser
  // --------------------------------------------------------------------------
  logic       rst_meta;
  logic       rstn_sync;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta  <= 1'b0;
      rstn_sync <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      rstn_sync <= rst_meta;
    end
  end

  always_ff @(posedge clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= format_select_code;
      pin_sync <= pin_meta;
    end
  end

  // --------------------------------------------------------------------------
  // host registers
  // --------------------------------------------------------------------------
  logic [23:0] disable_mask;
  logic [7:0]  out_config;
  logic [5:0]  host_code;
  logic [7:0]  hd_control;
  logic [7:0]  next_rdata;

  wire wr_mask0 = reg_write && (reg_addr == VSST_ADDR_MASK0);
  wire wr_mask1 = reg_write && (reg_addr == VSST_ADDR_MASK1);
  wire wr_mask2 = reg_write && (reg_addr == VSST_ADDR_MASK2);
  wire wr_cfg   = reg_write && (reg_addr == VSST_ADDR_OUT_CONFIG);
  wire wr_code  = reg_write && (reg_addr == VSST_ADDR_HOST_CODE);
  wire wr_hd    = reg_write && (reg_addr == VSST_ADDR_HD_CONTROL);
  wire [7:0] status_byte = {ref_recognized, 1'b0, detected_code};

  always_comb begin
    unique case (reg_addr)
      VSST_ADDR_MASK0:      next_rdata = disable_mask[7:0];
      VSST_ADDR_MASK1:      next_rdata = disable_mask[15:8];
      VSST_ADDR_MASK2:      next_rdata = disable_mask[23:16];
      VSST_ADDR_OUT_CONFIG: next_rdata = out_config;
      VSST_ADDR_HOST_CODE:  next_rdata = {2'b00, host_code};
      VSST_ADDR_HD_CONTROL: next_rdata = hd_control;
      VSST_ADDR_STATUS:     next_rdata = status_byte;
      default:              next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      disable_mask <= VSST_MASK_RESET;
      out_config   <= VSST_OUT_CONFIG_RESET;
      host_code    <= VSST_HOST_CODE_RESET;
      hd_control   <= VSST_HD_CONTROL_RESET;
      reg_rdata    <= 8'h00;
    end else begin
      if (wr_mask0) disable_mask[7:0]   <= reg_wdata;
      if (wr_mask1) disable_mask[15:8]  <= reg_wdata;
      if (wr_mask2) disable_mask[23:16] <= reg_wdata;
      if (wr_cfg)   out_config          <= reg_wdata;
      if (wr_code)  host_code           <= reg_wdata[5:0];
      if (wr_hd)    hd_control          <= reg_wdata;
      reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // reference format detector
  // --------------------------------------------------------------------------
  wire  [VSST_NUM_CODES-1:0] code_match;
  logic [5:0]                match_code;
  wire                       hd_on = hd_control[VSST_HD_ON_BIT];

  genvar gi;
  generate
    for (gi = 1; gi < VSST_NUM_CODES; gi++) begin : g_match
      localparam logic [5:0]   CODE = 6'(gi);
      localparam vsst_fmt_type FMT  = vsst_format(CODE);
      wire shape_ok = ((FMT.total == 12'h000) ||
                       (FMT.total == ref_line_clocks)) &&
                      (FMT.lines == ref_frame_lines) && (FMT.rate == ref_rate);
      if (gi < 11) begin : g_sd
        assign code_match[gi] = shape_ok;
      end else begin : g_hd
        assign code_match[gi] = shape_ok && hd_on &&
                                !disable_mask[gi - 11];
      end
    end
  endgenerate
  assign code_match[0] = 1'b0;

  always_comb begin
    match_code = 6'h00;
    for (int i = VSST_NUM_CODES - 1; i > 0; i--) begin
      if (code_match[i]) match_code = 6'(i);
    end
  end

  wire vsst_fmt_type match_fmt = vsst_format(match_code);
  wire match_tri = match_fmt.tri_level;

  always_ff @(posedge clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      detected_code  <= 6'h00;
      ref_recognized <= 1'b0;
      ref_tri_level  <= 1'b0;
    end else if (ref_measure_valid) begin
      detected_code  <= match_code;
      ref_recognized <= (match_code != 6'h00);
      ref_tri_level  <= match_tri;
    end
  end

  // --------------------------------------------------------------------------
  // output standard select and raster counters
  // --------------------------------------------------------------------------
  logic [11:0] px;
  logic [9:0]  ln;
  logic        clk_phase;

  wire [5:0] selected_code = out_config[VSST_HOST_SEL_BIT] ? host_code
                                                            : pin_sync;
  wire output_ok = (selected_code == 6'h01) ||
                   ((selected_code >= 6'h03) && (selected_code <= 6'h0a));
  wire vsst_fmt_type fmt = vsst_format(selected_code);
  wire restart  = (selected_code != active_code) || !output_ok;
  wire line_end = (px == fmt.total - 12'h001);
  wire [11:0] next_px = (restart || line_end) ? 12'h000 : px + 12'h001;
  wire frame_end = (ln == fmt.lines - 10'h001);
  wire [9:0] next_ln = restart ? 10'h000 :
                       !line_end ? ln : frame_end ? 10'h000 : ln + 10'h001;
  wire hs_on = output_ok && (next_px < 12'(fmt.hs_width));
  wire [9:0] vs_lines = 10'(fmt.vs_half[3:1]);
  wire vs_on = output_ok && ((next_ln < vs_lines) || (fmt.vs_half[0] &&
               (next_ln == vs_lines) && (next_px < {1'b0, fmt.total[11:1]})));
  wire de_on = output_ok &&
               (next_px >= fmt.total - fmt.active) &&
               (next_ln >= fmt.lines - fmt.active_lines);

  always_ff @(posedge clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      px             <= 12'h000;
      ln             <= 10'h000;
      active_code    <= 6'h00;
      pixel_rate     <= VSST_RATE_NONE;
      line_sync_n    <= 1'b1;
      frame_sync_n   <= 1'b1;
      display_enable <= 1'b0;
    end else begin
      px             <= next_px;
      ln             <= next_ln;
      active_code    <= selected_code;
      pixel_rate     <= output_ok ? fmt.rate : VSST_RATE_NONE;
      line_sync_n    <= !hs_on;
      frame_sync_n   <= !vs_on;
      display_enable <= de_on;
    end
  end

  // --------------------------------------------------------------------------
  // pixel clock outputs
  // --------------------------------------------------------------------------
  // code zero quiets clocks
  wire clocks_on = (selected_code != 6'h00) && output_ok;

  always_ff @(posedge clock or negedge rstn_sync) begin
    if (!rstn_sync) begin
      clk_phase                   <= 1'b0;
      single_ended_pixel_clock_a  <= 1'b0;
      single_ended_pixel_clock_b  <= 1'b0;
      differential_pixel_clock_p  <= 1'b0;
      differential_pixel_clock_n  <= 1'b1;
      differential_pixel_clock_oe <= 1'b0;
    end else begin
      clk_phase                   <= clocks_on && !clk_phase;
      single_ended_pixel_clock_a  <= clocks_on && !clk_phase;
      single_ended_pixel_clock_b  <= clocks_on && !clk_phase;
      differential_pixel_clock_p  <= clocks_on && !clk_phase;
      differential_pixel_clock_n  <= !(clocks_on && !clk_phase);
      differential_pixel_clock_oe <= clocks_on;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn_sync);

  sd_recognise_a: assert property (
    (ref_measure_valid && ref_line_clocks == 12'h6b4 &&
     ref_frame_lines == 10'h20d && ref_rate == VSST_RATE_27M)
    |=> (ref_recognized && detected_code == 6'h03))
    else $error("code three reference not recognised");

  hd_mask_gate_a: assert property (
    (ref_measure_valid && disable_mask[0])
    |=> (detected_code != 6'h0b))
    else $error("masked code eleven recognised");

  hd_enable_gate_a: assert property (
    (ref_measure_valid && !hd_on)
    |=> !(ref_recognized && detected_code >= VSST_FIRST_HD_CODE))
    else $error("hd recognised with enable off");

  hd_recognise_a: assert property (
    (ref_measure_valid && hd_on && !disable_mask[1] &&
     ref_line_clocks == 12'h672 && ref_frame_lines == 10'h2ee &&
     ref_rate == VSST_RATE_74M175)
    |=> (detected_code == 6'h0c && ref_tri_level))
    else $error("code twelve reference not recognised");

  host_select_a: assert property (
    out_config[VSST_HOST_SEL_BIT]
    |=> (active_code == $past(host_code)))
    else $error("host code not followed");

  code_zero_quiet_a: assert property (
    (selected_code == 6'h00)[*2]
    |-> (!single_ended_pixel_clock_a && !single_ended_pixel_clock_b &&
         !differential_pixel_clock_oe))
    else $error("clocks active on code zero");

  line_wrap_code1_a: assert property (
    (selected_code == 6'h01 && active_code == 6'h01 && px == 12'h38d)
    |=> (px == 12'h000))
    else $error("code one line length wrong");

  line_wrap_code7_a: assert property (
    (selected_code == 6'h07 && active_code == 6'h07 && px == 12'hd67)
    |=> (px == 12'h000))
    else $error("code seven line length wrong");

  hsync_width_a: assert property (
    (selected_code == 6'h03 && active_code == 6'h03 && px == 12'h07e)
    |-> (!line_sync_n ##1 line_sync_n))
    else $error("code three sync width wrong");

  sd_cover_c: cover property (ref_measure_valid ##1 ref_recognized);
  hd_cover_c: cover property (ref_measure_valid && hd_on ##1
                              detected_code >= VSST_FIRST_HD_CODE);
  raster_cover_c: cover property (active_code == 6'h04 && !frame_sync_n);
  host_cover_c: cover property (out_config[VSST_HOST_SEL_BIT] &&
                                display_enable);

endmodule // vsst_timing_gen

`default_nettype wire

// ---- testbench/vsst_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module vsst_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output var  logic [5:0] format_select_code,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write
);
  initial begin
    format_select_code = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
  end

  // --------------------------------------------------------------------------
  // register access
  // --------------------------------------------------------------------------
  // one-cycle strobe, data scrambled once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read data lands one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    @(negedge clock);
    d = reg_rdata;
  endtask

  // --------------------------------------------------------------------------
  // select pins
  // --------------------------------------------------------------------------
  // always driven, top bits low
  task automatic pins(input logic [3:0] code);
    @(posedge clock);
    format_select_code <= {2'b00, code};
  endtask

endmodule // vsst_host_model

`default_nettype wire

// ---- testbench/video_standard_select_timing_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module video_standard_select_timing_tb_top;
  import vsst_pkg::*;

  typedef struct packed {
    logic [5:0]    code;
    logic [11:0]   total;
    logic [9:0]    lines;
    vsst_rate_type rate;
    logic [7:0]    hs;
    logic          out;
  } vsst_row_type;

  logic          clock = 1'b0;
  logic          rstn = 1'b0;
  logic [5:0]    format_select_code;
  logic [7:0]    reg_addr;
  logic [7:0]    reg_wdata;
  logic          reg_write;
  logic [7:0]    reg_rdata;
  logic          ref_measure_valid = 1'b0;
  logic [11:0]   ref_line_clocks = 12'h000;
  logic [9:0]    ref_frame_lines = 10'h000;
  vsst_rate_type ref_rate = VSST_RATE_NONE;
  logic [5:0]    detected_code;
  logic          ref_recognized;
  logic          ref_tri_level;
  logic [5:0]    active_code;
  vsst_rate_type pixel_rate;
  logic          line_sync_n;
  logic          frame_sync_n;
  logic          display_enable;
  logic          single_ended_pixel_clock_a;
  logic          single_ended_pixel_clock_b;
  logic          differential_pixel_clock_p;
  logic          differential_pixel_clock_n;
  logic          differential_pixel_clock_oe;
  int            miscompares = 0;
  int            check_count = 0;
  logic [31:0]   lo;
  logic [31:0]   per;
  logic [7:0]    rv;
  logic          pa;
  logic [7:0]    ra [7] = '{8'h11, 8'h12, 8'h13, 8'h80, 8'h81, 8'h82, 8'h55};
  logic [7:0]    re [7] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  vsst_row_type  rows [10] = '{
    '{6'h01, 12'h38e, 10'h20d, VSST_RATE_14M32, 8'h1d, 1'b1},
    '{6'h02, 12'h000, 10'h271, VSST_RATE_COMPOSITE, 8'h00, 1'b0},
    '{6'h03, 12'h6b4, 10'h20d, VSST_RATE_27M, 8'h7f, 1'b1},
    '{6'h04, 12'h6c0, 10'h271, VSST_RATE_27M, 8'h7f, 1'b1},
    '{6'h05, 12'h8f0, 10'h20d, VSST_RATE_36M, 8'ha9, 1'b1},
    '{6'h06, 12'h900, 10'h271, VSST_RATE_36M, 8'ha9, 1'b1},
    '{6'h07, 12'hd68, 10'h20d, VSST_RATE_54M, 8'hfc, 1'b1},
    '{6'h08, 12'hd80, 10'h271, VSST_RATE_54M, 8'hfc, 1'b1},
    '{6'h09, 12'h6b4, 10'h20d, VSST_RATE_54M, 8'h7f, 1'b1},
    '{6'h0a, 12'h6c0, 10'h271, VSST_RATE_54M, 8'h7f, 1'b1}};

  always #20 clock = ~clock;

  vsst_host_model u_host (
    .clock              (clock),
    .reg_rdata          (reg_rdata),
    .format_select_code (format_select_code),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_write          (reg_write)
  );

  vsst_timing_gen u_dut (
    .clock                       (clock),
    .rstn                        (rstn),
    .format_select_code          (format_select_code),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .reg_write                   (reg_write),
    .reg_rdata                   (reg_rdata),
    .ref_measure_valid           (ref_measure_valid),
    .ref_line_clocks             (ref_line_clocks),
    .ref_frame_lines             (ref_frame_lines),
    .ref_rate                    (ref_rate),
    .detected_code               (detected_code),
    .ref_recognized              (ref_recognized),
    .ref_tri_level               (ref_tri_level),
    .active_code                 (active_code),
    .pixel_rate                  (pixel_rate),
    .line_sync_n                 (line_sync_n),
    .frame_sync_n                (frame_sync_n),
    .display_enable              (display_enable),
    .single_ended_pixel_clock_a  (single_ended_pixel_clock_a),
    .single_ended_pixel_clock_b  (single_ended_pixel_clock_b),
    .differential_pixel_clock_p  (differential_pixel_clock_p),
    .differential_pixel_clock_n  (differential_pixel_clock_n),
    .differential_pixel_clock_oe (differential_pixel_clock_oe)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic detect(input logic [11:0] c, input logic [9:0] l,
                        input vsst_rate_type r);
    @(posedge clock);
    ref_measure_valid <= 1'b1;
    ref_line_clocks   <= c;
    ref_frame_lines   <= l;
    ref_rate          <= r;
    @(posedge clock);
    ref_measure_valid <= 1'b0;
    ref_line_clocks   <= ~c;
    @(negedge clock);
  endtask

  // sync low width and line period, bounded
  task automatic measure(output logic [31:0] w, output logic [31:0] p);
    for (int n = 0; n < 4000 && line_sync_n !== 1'b1; n++) @(negedge clock);
    for (int n = 0; n < 4000 && line_sync_n !== 1'b0; n++) @(negedge clock);
    for (w = 0; w < 4000 && line_sync_n === 1'b0; w++) @(negedge clock);
    for (p = w; p < 4000 && line_sync_n === 1'b1; p++) @(negedge clock);
  endtask

  task automatic settle();
    repeat (6) @(posedge clock);
    @(negedge clock);
  endtask

  initial begin
    #4000000;
    miscompares++;
    end_of_test();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(line_sync_n, 1'b1);
    check(single_ended_pixel_clock_a, 1'b0);
    check(differential_pixel_clock_oe, 1'b0);
    @(posedge clock);
    rstn <= 1'b1;
    settle();
    for (int i = 0; i < 7; i++) begin
      u_host.rd(ra[i], rv);
      check(rv, re[i]);
    end
    for (int i = 0; i < 10; i++) begin
      detect(rows[i].total, rows[i].lines, rows[i].rate);
      check(detected_code, rows[i].code);
      check(ref_recognized, 1'b1);
      if (rows[i].out) begin
        u_host.pins(rows[i].code[3:0]);
        settle();
        check(active_code, rows[i].code);
        check(pixel_rate, rows[i].rate);
        check(differential_pixel_clock_oe, 1'b1);
        check(frame_sync_n, 1'b0);
        check(display_enable, 1'b0);
        measure(lo, per);
        check(lo, rows[i].hs);
        check(per, rows[i].total);
      end
    end
    detect(12'h672, 10'h2ee, VSST_RATE_74M25);
    check(ref_recognized, 1'b0);
    u_host.wr(8'h11, 8'hfe);
    detect(12'h672, 10'h2ee, VSST_RATE_74M25);
    check(ref_recognized, 1'b0);
    u_host.wr(8'h82, 8'h80);
    detect(12'h672, 10'h2ee, VSST_RATE_74M25);
    check(detected_code, 6'h0b);
    check(ref_recognized, 1'b1);
    check(ref_tri_level, 1'b1);
    detect(12'h672, 10'h2ee, VSST_RATE_74M175);
    check(ref_recognized, 1'b0);
    u_host.wr(8'h11, 8'hfc);
    u_host.rd(8'h11, rv);
    check(rv, 8'hfc);
    detect(12'h672, 10'h2ee, VSST_RATE_74M175);
    check(detected_code, 6'h0c);
    u_host.wr(8'h82, 8'h00);
    detect(12'h672, 10'h2ee, VSST_RATE_74M175);
    check(ref_recognized, 1'b0);
    u_host.wr(8'h81, 8'h05);
    u_host.wr(8'h80, 8'h02);
    settle();
    check(active_code, 6'h05);
    check(pixel_rate, VSST_RATE_36M);
    pa = single_ended_pixel_clock_a;
    @(negedge clock);
    check(single_ended_pixel_clock_a, !pa);
    check(differential_pixel_clock_n, !differential_pixel_clock_p);
    u_host.wr(8'h81, 8'h00);
    settle();
    check(single_ended_pixel_clock_a, 1'b0);
    check(single_ended_pixel_clock_b, 1'b0);
    check(differential_pixel_clock_oe, 1'b0);
    check(differential_pixel_clock_p, 1'b0);
    check(differential_pixel_clock_n, 1'b1);
    check(frame_sync_n, 1'b1);
    check(display_enable, 1'b0);
    @(negedge clock);
    check(single_ended_pixel_clock_a, 1'b0);
    u_host.wr(8'h81, 8'hc2);
    u_host.rd(8'h81, rv);
    check(rv, 8'h02);
    check(differential_pixel_clock_oe, 1'b0);
    check(pixel_rate, VSST_RATE_NONE);
    u_host.wr(8'h80, 8'h00);
    settle();
    check(active_code, 6'h0a);
    u_host.wr(8'h82, 8'h80);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    settle();
    u_host.rd(8'h82, rv);
    check(rv, 8'h00);
    u_host.rd(8'h13, rv);
    check(rv, 8'hff);
    end_of_test();
  end

endmodule // video_standard_select_timing_tb_top

`default_nettype wire
